// *** hw/cgm_bus_div.v ***
`timescale 1ns/1ps
`include "cgm_regs.vh"
module cgm_bus_div #(
   parameter WIDTH = 7
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             run,
   input  wire [2:0]       div_sel,
   output reg              bus_tick
);
   reg  [WIDTH-1:0] cnt_r;
   wire [WIDTH-1:0] mask;
   wire [WIDTH-1:0] cnt_nxt;

   // terminal count 2**div_sel - 1, so /128 fits the counter
   assign mask    = ~({WIDTH{1'b1}} << div_sel);
   assign cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};

   always @(posedge clock)
   begin
      if (rst)
      begin
         cnt_r    <= {WIDTH{1'b0}};
         bus_tick <= 1'b0;
      end
      else if (!run)
      begin
         bus_tick <= 1'b0;
      end
      else if (cnt_r >= mask)
      begin
         cnt_r    <= {WIDTH{1'b0}};
         bus_tick <= 1'b1;
      end
      else
      begin
         cnt_r    <= cnt_nxt;
         bus_tick <= 1'b0;
      end
   end
endmodule // cgm_bus_div

// *** hw/cgm_mode_ctrl.v ***
// Behaviour
// - off mode: output clock held static
// - self-clocked mode on leaving reset
// - self-clocked: loop open, oscillator free running
// - fei: multiple of internal reference
// - fei unlocked while attempting lock
// - fei locked once target reached
// - fbe routes external reference directly
// - fee: multiple of external reference
// - fee unlocked while attempting lock
// - fee locked once target reached
// - bus divider: eight powers, /1 to /128
// - reset or interrupt on clock/lock loss
// - status flags for lock and unlock
// - flag external reference valid
// - loop output selected whenever the oscillator runs outside off and fbe, before and after lock
// - never select a non-running source
// - oscillator reloaded in self-clocked fallback on reference loss
// - oscillator keeps setting across deep stop
// - loop output 8 to 40 MHz
// - drive fixed_freq_enable output
// - 8 MHz internal debug_local_clock source
// - separate self-clocked real-time source
// - decode clock_mode_select 00/01/10/11
// - fbe waits for external reference present
// - internal first write locks out external modes
// - prescale 64 low range, 1 high range
`timescale 1ns/1ps
`include "cgm_regs.vh"
module cgm_mode_ctrl #(
   parameter TRIM_W = 8
) (
   input  wire              clock,
   input  wire              rst,
   input  wire              mode_wr,
   input  wire [1:0]        mode_wdata,
   input  wire              range_high,
   input  wire [2:0]        bus_div_sel,
   input  wire              stop_req,
   input  wire              loss_reset_en,
   input  wire [TRIM_W-1:0] filter_setting,
   input  wire              ext_ref_present,
   input  wire              loop_on_target,
   input  wire              int_ref_running,
   input  wire              dco_running,
   input  wire              lock_flag_clear,
   output reg  [1:0]        clock_mode_select,
   output reg  [2:0]        mode_state,
   output reg  [1:0]        clk_src_sel,
   output reg               gen_clock_gate,
   output reg               loop_closed,
   output reg               loop_use_ext_ref,
   output reg  [6:0]        loop_prescale,
   output reg  [TRIM_W-1:0] dco_setting,
   output reg               fll_locked,
   output reg               lock_lost_flag,
   output reg               clock_lost_flag,
   output reg               ext_ref_clock_status,
   output reg               loss_irq,
   output reg               loss_reset_req,
   output wire              bus_tick,
   output reg               fixed_freq_enable,
   output reg               debug_local_clock_sel,
   output reg               rti_clock_sel
);
   reg  [2:0]        state_nxt;
   reg               first_wr_done_r;
   reg               ext_locked_out_r;
   reg  [2:0]        ext_sync_r;
   reg  [2:0]        tgt_sync_r;
   reg               ext_ok;
   reg               on_tgt;
   wire              lock_lost_ev;
   wire              clk_lost_ev;
   wire              wr_ok;

   // three-stage pin sync, change counted when stage 2 and 3 agree
   always @(posedge clock)
   begin
      if (rst)
      begin
         ext_sync_r <= 3'h0;
         tgt_sync_r <= 3'h0;
         ext_ok     <= 1'b0;
         on_tgt     <= 1'b0;
      end
      else
      begin
         ext_sync_r <= {ext_sync_r[1:0], ext_ref_present};
         tgt_sync_r <= {tgt_sync_r[1:0], loop_on_target};
         if (ext_sync_r[1] == ext_sync_r[2])
            ext_ok <= ext_sync_r[2];
         if (tgt_sync_r[1] == tgt_sync_r[2])
            on_tgt <= tgt_sync_r[2];
      end
   end

   // external writes refused after internal first write
   assign wr_ok = mode_wr && !(ext_locked_out_r && mode_wdata[1]);

   always @(posedge clock)
   begin
      if (rst)
      begin
         clock_mode_select <= `CGM_MODE_SCM;
         first_wr_done_r   <= 1'b0;
         ext_locked_out_r  <= 1'b0;
      end
      else if (wr_ok)
      begin
         clock_mode_select <= mode_wdata;
         first_wr_done_r   <= 1'b1;
         if (!first_wr_done_r && !mode_wdata[1])
            ext_locked_out_r <= 1'b1;
      end
   end

   // mode state machine
   always @*
   begin
      state_nxt = mode_state;
      if (stop_req)
         state_nxt = `CGM_ST_OFF;
      else
      begin
         case (clock_mode_select)
            `CGM_MODE_SCM:
               state_nxt = `CGM_ST_SCM;
            `CGM_MODE_FEI:
            begin
               if (!int_ref_running)
                  state_nxt = `CGM_ST_SCM;
               else if (on_tgt)
                  state_nxt = `CGM_ST_FEI_LOCK;
               else
                  state_nxt = `CGM_ST_FEI_UNLK;
            end
            `CGM_MODE_FBE:
            begin
               if (ext_ok)
                  state_nxt = `CGM_ST_FBE;
               else if (mode_state == `CGM_ST_FBE)
                  state_nxt = `CGM_ST_SCM;
               else
                  state_nxt = `CGM_ST_FBE_WAIT;
            end
            `CGM_MODE_FEE:
            begin
               if (!ext_ok)
                  state_nxt = `CGM_ST_SCM;
               else if (on_tgt)
                  state_nxt = `CGM_ST_FEE_LOCK;
               else
                  state_nxt = `CGM_ST_FEE_UNLK;
            end
            default:
               state_nxt = `CGM_ST_SCM;
         endcase
      end
   end

   assign lock_lost_ev = ((mode_state == `CGM_ST_FEI_LOCK) ||
                          (mode_state == `CGM_ST_FEE_LOCK)) && !on_tgt;
   assign clk_lost_ev  = ((mode_state == `CGM_ST_FBE) ||
                          (mode_state == `CGM_ST_FEE_LOCK) ||
                          (mode_state == `CGM_ST_FEE_UNLK)) && !ext_ok;

   always @(posedge clock)
   begin
      if (rst)
      begin
         mode_state            <= `CGM_ST_SCM;
         clk_src_sel           <= `CGM_SRC_DCO;
         gen_clock_gate        <= 1'b1;
         loop_closed           <= 1'b0;
         loop_use_ext_ref      <= 1'b0;
         loop_prescale         <= `CGM_PRESCALE_LOW;
         fll_locked            <= 1'b0;
         lock_lost_flag        <= 1'b0;
         clock_lost_flag       <= 1'b0;
         ext_ref_clock_status  <= 1'b0;
         loss_irq              <= 1'b0;
         loss_reset_req        <= 1'b0;
         fixed_freq_enable     <= 1'b0;
         debug_local_clock_sel <= 1'b0;
         rti_clock_sel         <= 1'b1;
      end
      else
      begin
         mode_state           <= state_nxt;
         ext_ref_clock_status <= ext_ok;
         gen_clock_gate       <= (state_nxt != `CGM_ST_OFF);
         loop_closed          <= (state_nxt == `CGM_ST_FEI_UNLK) ||
                                 (state_nxt == `CGM_ST_FEI_LOCK) ||
                                 (state_nxt == `CGM_ST_FEE_UNLK) ||
                                 (state_nxt == `CGM_ST_FEE_LOCK);
         loop_use_ext_ref     <= (state_nxt == `CGM_ST_FEE_UNLK) ||
                                 (state_nxt == `CGM_ST_FEE_LOCK);
         loop_prescale        <= range_high ? `CGM_PRESCALE_HIGH
                                            : `CGM_PRESCALE_LOW;
         fll_locked           <= (state_nxt == `CGM_ST_FEI_LOCK) ||
                                 (state_nxt == `CGM_ST_FEE_LOCK);
         case (state_nxt)
            `CGM_ST_OFF:
               clk_src_sel <= `CGM_SRC_NONE;
            `CGM_ST_FBE:
               clk_src_sel <= `CGM_SRC_EXT;
            default:
               clk_src_sel <= dco_running ? `CGM_SRC_DCO : `CGM_SRC_NONE;
         endcase
         // sticky flags, set wins over clear
         if (lock_lost_ev)
            lock_lost_flag <= 1'b1;
         else if (lock_flag_clear)
            lock_lost_flag <= 1'b0;
         if (clk_lost_ev)
            clock_lost_flag <= 1'b1;
         else if (lock_flag_clear)
            clock_lost_flag <= 1'b0;
         loss_irq       <= !loss_reset_en &&
                           (lock_lost_flag || clock_lost_flag ||
                            lock_lost_ev || clk_lost_ev);
         loss_reset_req <= loss_reset_en && (lock_lost_ev || clk_lost_ev);
         fixed_freq_enable     <= (state_nxt != `CGM_ST_OFF) &&
                                  (state_nxt != `CGM_ST_SCM);
         debug_local_clock_sel <= int_ref_running;
         rti_clock_sel         <= 1'b1;
      end
   end

   // oscillator setting: loaded only in self-clocked state, kept otherwise
   always @(posedge clock)
   begin
      if (rst)
         dco_setting <= `CGM_TRIM_RST;
      else if (mode_state == `CGM_ST_SCM)
         dco_setting <= filter_setting;
      // held through off mode; reloaded after reference loss falls back to self-clocked
   end

   cgm_bus_div #(
      .WIDTH (7)
   ) u_div (
      .clock    (clock),
      .rst      (rst),
      .run      (gen_clock_gate),
      .div_sel  (bus_div_sel),
      .bus_tick (bus_tick)
   );
endmodule // cgm_mode_ctrl

// *** include/cgm_regs.vh ***
`ifndef CGM_REGS_VH
`define CGM_REGS_VH
// clock_mode_select encodings
`define CGM_MODE_SCM        2'h0
`define CGM_MODE_FEI        2'h1
`define CGM_MODE_FBE        2'h2
`define CGM_MODE_FEE        2'h3
// controller states
`define CGM_ST_OFF          3'h0
`define CGM_ST_SCM          3'h1
`define CGM_ST_FEI_UNLK     3'h2
`define CGM_ST_FEI_LOCK     3'h3
`define CGM_ST_FBE_WAIT     3'h4
`define CGM_ST_FBE          3'h5
`define CGM_ST_FEE_UNLK     3'h6
`define CGM_ST_FEE_LOCK     3'h7
// clock source select codes
`define CGM_SRC_NONE        2'h0
`define CGM_SRC_DCO         2'h1
`define CGM_SRC_EXT         2'h2
// prescale factors
`define CGM_PRESCALE_LOW    7'h40
`define CGM_PRESCALE_HIGH   7'h01
// loop output range and other clock rates in MHz
`define CGM_FLL_MIN_MHZ     8
`define CGM_FLL_MAX_MHZ     40
`define CGM_BUS_MAX_MHZ     20
`define CGM_DBG_CLK_MHZ     8
// reset values
`define CGM_DIV_RST         3'h0
`define CGM_TRIM_RST        8'h80
`endif

// *** sim/cgm_mode_ctrl_asserts.sv ***
`timescale 1ns/1ps
`include "cgm_regs.vh"
module cgm_mode_ctrl_chk (
   input logic       clock,
   input logic       rst,
   input logic       mode_wr,
   input logic [1:0] mode_wdata,
   input logic       range_high,
   input logic [2:0] bus_div_sel,
   input logic       stop_req,
   input logic       loss_reset_en,
   input logic [1:0] clock_mode_select,
   input logic [2:0] mode_state,
   input logic [1:0] clk_src_sel,
   input logic       gen_clock_gate,
   input logic       loop_closed,
   input logic       loop_use_ext_ref,
   input logic [6:0] loop_prescale,
   input logic       ext_ref_clock_status,
   input logic       loss_reset_req,
   input logic       bus_tick
);
   logic first_r;
   logic lock_r;
   // track whether the first mode write chose an internal mode
   always @(posedge clock)
   begin
      if (rst)
      begin
         first_r <= 1'b0;
         lock_r  <= 1'b0;
      end
      else if (mode_wr && !first_r)
      begin
         first_r <= 1'b1;
         lock_r  <= !mode_wdata[1];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_off; stop_req[*3] |-> !gen_clock_gate; endproperty
   a_off: assert property (p_off) else $error("clock not static");
   property p_rst; $fell(rst) |-> mode_state == `CGM_ST_SCM && clock_mode_select == 2'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("not self-clocked after reset");
   property p_scm; mode_state == `CGM_ST_SCM |-> !loop_closed; endproperty
   a_scm: assert property (p_scm) else $error("loop closed in self-clocked");
   property p_fei; mode_state == `CGM_ST_FEI_UNLK |-> loop_closed && !loop_use_ext_ref;
   endproperty
   a_fei: assert property (p_fei) else $error("internal loop setup wrong");
   property p_fbe; mode_state == `CGM_ST_FBE |-> clk_src_sel == `CGM_SRC_EXT && !loop_closed;
   endproperty
   a_fbe: assert property (p_fbe) else $error("bypass not direct");
   property p_div; bus_tick && bus_div_sel == 3'h2 |=> (!bus_tick)[*3]; endproperty
   a_div: assert property (p_div) else $error("bus tick early");
   property p_lrq; loss_reset_req |-> loss_reset_en; endproperty
   a_lrq: assert property (p_lrq) else $error("reset request not enabled");
   property p_wr; mode_wr && !mode_wdata[1] |=> clock_mode_select == $past(mode_wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("mode write lost");
   property p_ext; clk_src_sel == `CGM_SRC_EXT |-> ext_ref_clock_status; endproperty
   a_ext: assert property (p_ext) else $error("external source without reference");
   property p_lk; mode_wr && mode_wdata[1] && lock_r |=> $stable(clock_mode_select);
   endproperty
   a_lk: assert property (p_lk) else $error("external write accepted");
   property p_pre; range_high[*3] |-> loop_prescale == `CGM_PRESCALE_HIGH; endproperty
   a_pre: assert property (p_pre) else $error("prescale wrong");
endmodule // cgm_mode_ctrl_chk
bind cgm_mode_ctrl cgm_mode_ctrl_chk u_chk (.clock, .rst, .mode_wr, .mode_wdata, .range_high,
   .bus_div_sel, .stop_req, .loss_reset_en, .clock_mode_select, .mode_state, .clk_src_sel,
   .gen_clock_gate, .loop_closed, .loop_use_ext_ref, .loop_prescale, .ext_ref_clock_status,
   .loss_reset_req, .bus_tick);

// *** sim/cgm_testbench.sv ***
`timescale 1ns/1ps
`include "cgm_regs.vh"
module testbench;
   logic       clock = 0, rst = 1, mode_wr = 0, range_high = 0, stop_req = 0;
   logic       loss_reset_en = 1, ext_ref_present = 0, loop_on_target = 0, flag_clr = 0;
   logic [1:0] mode_wdata = 0, cms, src;
   logic [2:0] bus_div_sel = 0, st;
   logic [6:0] pre;
   logic [7:0] controlled_oscillator;
   logic       gate, locked, clost, use_ext, tick, rti;
   int         n_errors = 0, compares = 0, cnt;
   always #5 clock = ~clock;
   cgm_mode_ctrl uut (.clock(clock), .rst(rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .range_high(range_high), .bus_div_sel(bus_div_sel), .stop_req(stop_req),
      .loss_reset_en(loss_reset_en), .filter_setting(8'h5A), .ext_ref_present(ext_ref_present),
      .loop_on_target(loop_on_target), .int_ref_running(1'b1), .dco_running(1'b1),
      .lock_flag_clear(flag_clr), .clock_mode_select(cms), .mode_state(st), .clk_src_sel(src),
      .gen_clock_gate(gate), .loop_closed(), .loop_use_ext_ref(use_ext), .loop_prescale(pre),
      .dco_setting(controlled_oscillator), .fll_locked(locked), .lock_lost_flag(), .clock_lost_flag(clost),
      .ext_ref_clock_status(), .loss_irq(), .loss_reset_req(), .bus_tick(tick),
      .fixed_freq_enable(), .debug_local_clock_sel(), .rti_clock_sel(rti));
   task tally_and_finish;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task do_reset;
      @(posedge clock);
      rst <= 1;
      wt(3);
      @(posedge clock);
      rst <= 0;
      wt(1);
   endtask
   task wr_mode(input logic [1:0] d);
      @(posedge clock);
      mode_wr <= 1;
      mode_wdata <= d;
      @(posedge clock);
      mode_wr <= 0;
      wt(3);
   endtask
   initial
   begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
   initial
   begin
      do_reset;
      chk("state", st, `CGM_ST_SCM);
      chk("mode", cms, 8'h00);
      chk("src", src, `CGM_SRC_DCO);
      chk("gate", gate, 8'h01);
      chk("dco", controlled_oscillator, 8'h5A);
      chk("rti", rti, 8'h01);
      $display("reset test done");
      for (int s = 0; s < 8; s++)
      begin
         @(posedge clock);
         bus_div_sel <= s[2:0];
         wt(130);
         cnt = 0;
         repeat (256)
         begin
            wt(1);
            cnt += tick;
         end
         chk("ticks", cnt[7:0], 8'((256 >> s) & 8'hFF));
      end
      $display("divider test done");
      wr_mode(`CGM_MODE_FEI);
      chk("fei unlk", st, `CGM_ST_FEI_UNLK);
      @(posedge clock);
      loop_on_target <= 1;
      wt(8);
      chk("fei lock", st, `CGM_ST_FEI_LOCK);
      chk("locked", locked, 8'h01);
      @(posedge clock);
      loop_on_target <= 0;
      wr_mode(`CGM_MODE_FEE);
      chk("lockout", cms, `CGM_MODE_FEI);
      wr_mode(`CGM_MODE_SCM);
      chk("scm", st, `CGM_ST_SCM);
      @(posedge clock);
      stop_req <= 1;
      wt(4);
      chk("off gate", gate, 8'h00);
      @(posedge clock);
      stop_req <= 0;
      $display("internal test done");
      do_reset;
      wr_mode(`CGM_MODE_FBE);
      chk("fbe wait", st, `CGM_ST_FBE_WAIT);
      @(posedge clock);
      ext_ref_present <= 1;
      wt(8);
      chk("fbe", st, `CGM_ST_FBE);
      chk("fbe src", src, `CGM_SRC_EXT);
      wr_mode(`CGM_MODE_FEE);
      chk("fee unlk", st, `CGM_ST_FEE_UNLK);
      chk("fee ref", use_ext, 8'h01);
      @(posedge clock);
      loop_on_target <= 1;
      wt(8);
      chk("fee lock", st, `CGM_ST_FEE_LOCK);
      @(posedge clock);
      ext_ref_present <= 0;
      wt(8);
      chk("lost", clost, 8'h01);
      chk("fallback", st, `CGM_ST_SCM);
      @(posedge clock);
      range_high <= 1;
      wt(4);
      chk("prescale", pre, `CGM_PRESCALE_HIGH);
      $display("external test done");
      tally_and_finish;
   end
endmodule // testbench
